// [ihpff_port.sv]
// Host bus port: pin decode, page registers, event queue, DMA, indicators and frame FIFOs.
`timescale 1ns/100ps
`default_nettype none

module ihpff_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_n,
	// Filling side.
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Draining side.
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	wire              push = i_in_valid & o_in_ready;
	wire              load = (cnt_r != '0) & (~o_out_valid | i_out_ready);
	// The ready flag is registered from the next count, so it never admits a word too many.
	assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wp_r        <= '0;
			rp_r        <= '0;
			cnt_r       <= '0;
			o_in_ready  <= 1'b0;
			o_out_valid <= 1'b0;
			o_out_data  <= '0;
		end
		else
		begin
			cnt_r      <= cnt_nxt;
			o_in_ready <= (cnt_nxt != DEPTH[AW:0]);
			if (push)
				wp_r <= wp_r + 1'b1;
			if (load)
			begin
				rp_r        <= rp_r + 1'b1;
				o_out_data  <= mem_r[rp_r];
				o_out_valid <= 1'b1;
			end
			else if (i_out_ready)
				o_out_valid <= 1'b0;
		end
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (push)
			mem_r[wp_r] <= i_in_data;
	end
endmodule : ihpff_fifo

// Behaviour
// - Link indicator low while link pulses are valid, unless host control is enabled.
// - Under host control the link indicator is low only when its host bit is set.
// - Bus status indicator low while receive traffic causes a bus access.
// - Under host control the bus status indicator follows the second host bit.
// - Network indicator pulses low for 6 ms per receive, transmit or collision.
// - In standby the network indicator is low while the receiver sees activity.
// - Test input low selects scan test mode; high is normal operation.
// - Suspend and standby are allowed only while the sleep input is low.
// - A transmit command sets threshold, CRC and pad choices before frame data.
// - Frame start is signalled once the chosen byte threshold sits in the buffer.
// - With padding on, frames below 64 bytes including CRC get pad bytes. The code pads only when CRC generation is also selected.
// - A 32-bit check value is appended when CRC generation is selected.
// - Receive words are stored only on address match; good CRC raises the event.
// - Memory mode maps registers and buffers into a 4-Kbyte block.
// - I/O mode is always on: eight 16-bit ports over sixteen addresses.
// - I/O access needs address enable low, address match and a strobe low.
// - Only the interrupt line chosen at 0022h is driven; others float.
// - Interrupt rises on an enabled event, falls after an all-zero queue read.
// - Only the DMA pair chosen at 0024h is used; other requests float.
// - DMA request rises while received frames wait for DMA transfer.
// - Request drops at completion, or 32 us after start when burst is set.
// - While refresh is low all strobes and DMA acknowledges are ignored.
// - The wide I/O select is driven low on an I/O address hit, else floats.
module ihpff_port #(
	parameter int NET_PULSE_CYC = ihpff_pkg::NET_PULSE_CYC,
	parameter int BURST_CYC     = ihpff_pkg::BURST_CYC
) (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Host bus pins.
	input  wire logic [15:0] i_sa,
	input  wire logic [15:0] i_sd,
	output logic      [15:0] o_sd,
	output logic             o_sd_oe,
	input  wire logic        i_aen,
	input  wire logic        i_ior_n,
	input  wire logic        i_iow_n,
	input  wire logic        i_memr_n,
	input  wire logic        i_memw_n,
	input  wire logic        i_chipsel_n,
	input  wire logic        i_refresh_n,
	input  wire logic [2:0]  i_transfer_ack_lines_n,
	output logic [3:0]       o_irq_output_lines,
	output logic [3:0]       o_irq_output_lines_oe,
	output logic [2:0]       o_transfer_request_lines,
	output logic [2:0]       o_transfer_request_lines_oe,
	output logic             o_io_wide_select_out,
	output logic             o_io_wide_select_out_oe,
	// Mode pins.
	input  wire logic        i_test_n,
	input  wire logic        i_sleep_n,
	output logic             o_scan_mode,
	output logic             o_standby,
	output logic             o_suspend,
	// Indicator pins: link, bus activity, network activity.
	output logic [2:0]       o_indicator,
	output logic [2:0]       o_indicator_oe,
	// Network side events.
	input  wire logic        i_link_ok,
	input  wire logic        i_net_activity,
	input  wire logic        i_rx_packet,
	input  wire logic        i_tx_packet,
	input  wire logic        i_collision,
	// Transmit stream to the MAC.
	output logic             o_tx_start,
	output logic             o_tx_crc_en,
	output logic [10:0]      o_tx_pad_bytes,
	output logic [10:0]      o_tx_len,
	output logic             o_tx_valid,
	output logic [15:0]      o_tx_data,
	input  wire logic        i_tx_ready,
	input  wire logic        i_tx_done,
	// Receive stream from the MAC.
	input  wire logic        i_rx_valid,
	input  wire logic [15:0] i_rx_data,
	input  wire logic        i_rx_match,
	input  wire logic        i_rx_end,
	input  wire logic        i_rx_crc_ok,
	output logic             o_rx_ready
);
	// Pin synchroniser: three stages, a change counts once stages two and three agree.
	localparam int NS = 44;
	localparam logic [NS-1:0] SYNC_RST = {32'h0000_0000, 12'hfff};
	logic [NS-1:0] s1_r, s2_r, s3_r, f_r;
	wire  [NS-1:0] pins = {i_sa, i_sd, i_aen, i_ior_n, i_iow_n, i_memr_n, i_memw_n,
		i_chipsel_n, i_refresh_n, i_test_n, i_sleep_n, i_transfer_ack_lines_n};
	generate
		for (genvar g = 0; g < NS; g++)
		begin : g_sync
			always_ff @(posedge i_clk_sys or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					s1_r[g] <= SYNC_RST[g];
					s2_r[g] <= SYNC_RST[g];
					s3_r[g] <= SYNC_RST[g];
					f_r[g]  <= SYNC_RST[g];
				end
				else
				begin
					s1_r[g] <= pins[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g])
						f_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate
	wire [15:0] sa        = f_r[43:28];
	wire [15:0] sd        = f_r[27:12];
	wire        aen       = f_r[11];
	wire        refresh_n = f_r[5];
	wire        test_n    = f_r[4];
	wire        sleep_n   = f_r[3];
	wire [2:0]  dack_n    = f_r[2:0];

	// Registers.
	logic [15:0] io_base_r, irq_sel_r, dma_sel_r, self_r, bus_r, ptr_r;
	logic [15:0] txcmd_r, events_r;
	logic [10:0] txlen_r, txbytes_r;
	logic        tx_armed_r, tx_started_r, irq_r, dma_req_r, burst_hold_r, dma_run_r;
	logic [7:0]  rx_frames_r;
	logic        rd_d_r, wr_d_r, dma_d_r;
	logic [$clog2(NET_PULSE_CYC+1)-1:0] net_cnt_r;
	logic [$clog2(BURST_CYC+1)-1:0]     burst_cnt_r;

	// Port number to page offset; the data, command, length and event ports map to fixed pages, the other ports go through the page pointer.
	function automatic logic [15:0] port_page(input logic [2:0] port, input logic [15:0] ptr);
		unique case (port)
			ihpff_pkg::PORT_DATA:    port_page = ihpff_pkg::PG_FRAME_DATA;
			ihpff_pkg::PORT_TX_CMD:  port_page = ihpff_pkg::PG_TX_CMD;
			ihpff_pkg::PORT_TX_LEN:  port_page = ihpff_pkg::PG_TX_LEN;
			ihpff_pkg::PORT_EVENT_Q: port_page = ihpff_pkg::PG_EVENT_Q;
			default:                 port_page = ptr;
		endcase
	endfunction : port_page

	// Line select decode, shared by the interrupt and DMA pins.
	function automatic logic [3:0] line_sel(input logic [15:0] sel, input logic [2:0] lines);
		line_sel = (sel[15:2] == 14'h0000 && {1'b0, sel[1:0]} < lines) ?
			4'h1 << sel[1:0] : 4'h0;
	endfunction : line_sel

	// Access decode.
	wire        io_hit   = refresh_n & ~aen & (sa[15:4] == io_base_r[15:4]);
	wire        mem_hit  = bus_r[ihpff_pkg::BUS_MEM_EN] & ~f_r[6];
	wire        io_rd    = refresh_n & io_hit & ~f_r[10];
	wire        io_wr    = refresh_n & io_hit & ~f_r[9];
	wire        mem_rd   = refresh_n & mem_hit & ~f_r[8];
	wire        mem_wr   = refresh_n & mem_hit & ~f_r[7];
	wire [3:0]  irq_lines = line_sel(irq_sel_r, 3'h4);
	wire [3:0]  dma_lines = line_sel(dma_sel_r, 3'h3);
	wire        dma_ack  = refresh_n & |(dma_lines[2:0] & ~dack_n);
	wire        dma_rd   = dma_ack & ~f_r[10];
	wire        is_ptr   = io_rd | io_wr ? sa[3:1] == ihpff_pkg::PORT_PTR : 1'b0;
	wire [15:0] addr     = (io_rd | io_wr) ? port_page(sa[3:1], ptr_r) : {4'h0, sa[11:0]};
	wire        rd_act   = io_rd | mem_rd;
	wire        wr_act   = io_wr | mem_wr;
	wire        rd_go    = rd_act & ~rd_d_r;
	wire        wr_go    = wr_act & ~wr_d_r;
	wire        dma_go   = dma_rd & ~dma_d_r;

	// Frame FIFOs.
	logic        txf_rdy, rxf_valid;
	logic [15:0] rxf_data;
	wire         tx_push  = wr_go & ~is_ptr & (addr == ihpff_pkg::PG_FRAME_DATA) & tx_armed_r;
	wire         rx_hread = rd_go & ~is_ptr & (addr == ihpff_pkg::PG_FRAME_DATA);
	wire         rx_pop   = rx_hread | dma_go;
	wire         rx_store = i_rx_valid & i_rx_match;
	ihpff_fifo #(.WIDTH(ihpff_pkg::FIFO_W), .DEPTH(ihpff_pkg::FIFO_D)) u_tx_fifo (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (i_rst_n),
		.i_in_valid (tx_push),
		.i_in_data  (sd),
		.o_in_ready (txf_rdy),
		.o_out_valid(o_tx_valid),
		.o_out_data (o_tx_data),
		.i_out_ready(i_tx_ready & tx_started_r)
	);
	ihpff_fifo #(.WIDTH(ihpff_pkg::FIFO_W), .DEPTH(ihpff_pkg::FIFO_D)) u_rx_fifo (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (i_rst_n),
		.i_in_valid (rx_store),
		.i_in_data  (i_rx_data),
		.o_in_ready (o_rx_ready),
		.o_out_valid(rxf_valid),
		.o_out_data (rxf_data),
		.i_out_ready(rx_pop)
	);

	// Transmit threshold and padding.
	wire [1:0]  thr_sel  = txcmd_r[ihpff_pkg::TXC_THR_LO +: 2];
	wire [10:0] thr      = (thr_sel == 2'h0) ? ihpff_pkg::THR_5 :
		(thr_sel == 2'h1) ? ihpff_pkg::THR_381 :
		(thr_sel == 2'h2) ? ihpff_pkg::THR_1021 : txlen_r;
	wire [10:0] thr_eff  = (thr > txlen_r) ? txlen_r : thr;
	wire        crc_en   = ~txcmd_r[ihpff_pkg::TXC_NO_CRC];
	wire        pad_en   = ~txcmd_r[ihpff_pkg::TXC_NO_PAD] & crc_en;
	wire [10:0] pad      = (pad_en && txlen_r < ihpff_pkg::MIN_BODY) ?
		ihpff_pkg::MIN_BODY - txlen_r : 11'h000;
	wire        tx_go    = tx_armed_r & ~tx_started_r & (txbytes_r >= thr_eff)
		& (txlen_r != 11'h000);
	wire        tx_rdy   = tx_armed_r & txf_rdy;

	// Register read mux.
	wire [15:0] stat_word = {7'h00, tx_rdy, rx_frames_r};
	wire [15:0] rd_word =
		is_ptr                               ? ptr_r :
		(addr == ihpff_pkg::PG_IO_BASE)      ? io_base_r :
		(addr == ihpff_pkg::PG_IRQ_SEL)      ? irq_sel_r :
		(addr == ihpff_pkg::PG_DMA_SEL)      ? dma_sel_r :
		(addr == ihpff_pkg::PG_SELF_CTL)     ? self_r :
		(addr == ihpff_pkg::PG_BUS_CTL)      ? bus_r :
		(addr == ihpff_pkg::PG_EVENT_Q)      ? events_r :
		(addr == ihpff_pkg::PG_BUS_STAT)     ? stat_word :
		(addr == ihpff_pkg::PG_TX_CMD)       ? txcmd_r :
		(addr == ihpff_pkg::PG_TX_LEN)       ? {5'h00, txlen_r} :
		(addr == ihpff_pkg::PG_FRAME_DATA)   ? rxf_data : 16'h0000;
	wire        evq_read  = rd_go & ~is_ptr & (addr == ihpff_pkg::PG_EVENT_Q);
	wire [15:0] ev_set    = {12'h000, tx_armed_r & i_tx_done,
		i_rx_end & i_rx_match & i_rx_crc_ok, 2'h0};
	wire        rx_drained = (rd_d_r | dma_d_r) & ~rxf_valid;
	wire        net_event = i_rx_packet | i_tx_packet | i_collision;

	// Host writes, event queue and transmit sequencing.
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			io_base_r    <= ihpff_pkg::RST_IO_BASE;
			irq_sel_r    <= ihpff_pkg::RST_IRQ_SEL;
			dma_sel_r    <= ihpff_pkg::RST_DMA_SEL;
			self_r       <= ihpff_pkg::RST_CTL;
			bus_r        <= ihpff_pkg::RST_CTL;
			ptr_r        <= ihpff_pkg::RST_PTR;
			txcmd_r      <= ihpff_pkg::RST_CTL;
			txlen_r      <= 11'h000;
			events_r     <= 16'h0000;
			tx_armed_r   <= 1'b0;
			tx_started_r <= 1'b0;
			txbytes_r    <= 11'h000;
			irq_r        <= 1'b0;
			rd_d_r       <= 1'b0;
			wr_d_r       <= 1'b0;
			dma_d_r      <= 1'b0;
		end
		else
		begin
			rd_d_r  <= rd_act;
			wr_d_r  <= wr_act;
			dma_d_r <= dma_rd;
			if (wr_go && is_ptr)
				ptr_r <= sd;
			else if (wr_go)
			begin
				unique case (addr)
					ihpff_pkg::PG_IO_BASE:  io_base_r <= sd;
					ihpff_pkg::PG_IRQ_SEL:  irq_sel_r <= sd;
					ihpff_pkg::PG_DMA_SEL:  dma_sel_r <= sd;
					ihpff_pkg::PG_SELF_CTL: self_r    <= sd;
					ihpff_pkg::PG_BUS_CTL:  bus_r     <= sd;
					ihpff_pkg::PG_TX_LEN:   txlen_r   <= sd[10:0];
					default:                ;
				endcase
			end
			// A new command restarts the sequence; data before it is not taken.
			if (wr_go && !is_ptr && addr == ihpff_pkg::PG_TX_CMD)
			begin
				txcmd_r      <= sd;
				tx_armed_r   <= 1'b1;
				tx_started_r <= 1'b0;
				txbytes_r    <= 11'h000;
			end
			else
			begin
				if (tx_push)
					txbytes_r <= txbytes_r + 11'h002;
				if (tx_go)
					tx_started_r <= 1'b1;
				if (i_tx_done)
					tx_armed_r <= 1'b0;
			end
			// A read empties the queue, but an event landing in the same cycle is kept.
			events_r <= (evq_read ? 16'h0000 : events_r) | ev_set;
			if (bus_r[ihpff_pkg::BUS_IRQ_EN] && ev_set != 16'h0000)
				irq_r <= 1'b1;
			else if (evq_read && events_r == 16'h0000)
				irq_r <= 1'b0;
		end
	end

	// DMA request, frame count and burst timer.
	wire dma_want = bus_r[ihpff_pkg::BUS_DMA_EN] & (rx_frames_r != 8'h00);
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_frames_r  <= 8'h00;
			dma_req_r    <= 1'b0;
			dma_run_r    <= 1'b0;
			burst_hold_r <= 1'b0;
			burst_cnt_r  <= '0;
		end
		else
		begin
			if (ev_set[ihpff_pkg::EVQ_RX])
				rx_frames_r <= rx_frames_r + 8'h01;
			else if (rx_drained)
				rx_frames_r <= 8'h00;
			if (dma_go && !dma_run_r)
				dma_run_r <= 1'b1;
			else if (!dma_want)
				dma_run_r <= 1'b0;
			if (dma_go && !dma_run_r)
				burst_cnt_r <= '0;
			else if (dma_run_r && burst_cnt_r != BURST_CYC[$bits(burst_cnt_r)-1:0])
				burst_cnt_r <= burst_cnt_r + 1'b1;
			if (dma_run_r && bus_r[ihpff_pkg::BUS_BURST]
				&& burst_cnt_r == BURST_CYC[$bits(burst_cnt_r)-1:0])
				burst_hold_r <= 1'b1;
			else if (!dma_ack)
				burst_hold_r <= 1'b0;
			dma_req_r <= dma_want & ~burst_hold_r;
		end
	end

	// Pin outputs, indicators and modes.
	wire standby = ~sleep_n & self_r[ihpff_pkg::SELF_STANDBY];
	wire suspend = ~sleep_n & self_r[ihpff_pkg::SELF_SUSPEND] & ~standby;
	wire link_lo = self_r[ihpff_pkg::SELF_FIRST_HOST_DRIVE_ENABLE] ? self_r[ihpff_pkg::SELF_HCB0] : i_link_ok;
	wire bus_lo  = self_r[ihpff_pkg::SELF_SECOND_HOST_DRIVE_ENABLE] ? self_r[ihpff_pkg::SELF_SECOND_HOST_DRIVE_VALUE] :
		(rx_hread | dma_rd);
	wire net_lo  = standby ? i_net_activity : (net_cnt_r != '0);
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			net_cnt_r                   <= '0;
			o_sd                        <= 16'h0000;
			o_sd_oe                     <= 1'b0;
			o_irq_output_lines          <= 4'h0;
			o_irq_output_lines_oe       <= 4'h0;
			o_transfer_request_lines    <= 3'h0;
			o_transfer_request_lines_oe <= 3'h0;
			o_io_wide_select_out        <= 1'b0;
			o_io_wide_select_out_oe     <= 1'b0;
			o_scan_mode                 <= 1'b0;
			o_standby                   <= 1'b0;
			o_suspend                   <= 1'b0;
			o_indicator                 <= 3'h0;
			o_indicator_oe              <= 3'h0;
			o_tx_start                  <= 1'b0;
			o_tx_crc_en                 <= 1'b0;
			o_tx_pad_bytes              <= 11'h000;
			o_tx_len                    <= 11'h000;
		end
		else
		begin
			// A standby pulse would be lost in its own timer, so the timer is cleared there.
			if (standby)
				net_cnt_r <= '0;
			else if (net_event)
				net_cnt_r <= NET_PULSE_CYC[$bits(net_cnt_r)-1:0];
			else if (net_cnt_r != '0)
				net_cnt_r <= net_cnt_r - 1'b1;
			if (rd_go || dma_go)
				o_sd                    <= dma_rd ? rxf_data : rd_word;
			o_sd_oe                     <= rd_act | dma_rd;
			o_irq_output_lines          <= irq_lines & {4{irq_r}};
			o_irq_output_lines_oe       <= irq_lines;
			o_transfer_request_lines    <= dma_lines[2:0] & {3{dma_req_r}};
			o_transfer_request_lines_oe <= dma_lines[2:0];
			o_io_wide_select_out_oe     <= io_hit;
			o_scan_mode                 <= ~test_n;
			o_standby                   <= standby;
			o_suspend                   <= suspend;
			o_indicator_oe              <= {net_lo, bus_lo, link_lo};
			o_tx_start                  <= tx_go;
			o_tx_crc_en                 <= crc_en;
			o_tx_pad_bytes              <= pad;
			o_tx_len                    <= txlen_r;
		end
	end
endmodule : ihpff_port
`default_nettype wire

// [ihpff_pkg.sv]
// Shared constants of the host bus port: page offsets, fields, reset values and timing.
`default_nettype none
package ihpff_pkg;
	// Timing, in the units printed, and the clock rate.
	localparam int CLK_MHZ          = 250;
	localparam int NET_PULSE_MS     = 6;
	localparam int BURST_US         = 32;
	localparam int NET_PULSE_CYC    = NET_PULSE_MS * 1000 * CLK_MHZ;
	localparam int BURST_CYC        = BURST_US * CLK_MHZ;
	// Page offsets of the registers.
	localparam logic [15:0] PG_IO_BASE      = 16'h0020;
	localparam logic [15:0] PG_IRQ_SEL      = 16'h0022;
	localparam logic [15:0] PG_DMA_SEL      = 16'h0024;
	localparam logic [15:0] PG_SELF_CTL     = 16'h0114;
	localparam logic [15:0] PG_BUS_CTL      = 16'h0116;
	localparam logic [15:0] PG_EVENT_Q      = 16'h0120;
	localparam logic [15:0] PG_BUS_STAT     = 16'h0138;
	localparam logic [15:0] PG_TX_CMD       = 16'h0144;
	localparam logic [15:0] PG_TX_LEN       = 16'h0146;
	localparam logic [15:0] PG_FRAME_DATA   = 16'h0400;
	// I/O port numbers, counted in 16-bit ports from the I/O base.
	localparam logic [2:0]  PORT_DATA       = 3'h0;
	localparam logic [2:0]  PORT_TX_CMD     = 3'h2;
	localparam logic [2:0]  PORT_TX_LEN     = 3'h3;
	localparam logic [2:0]  PORT_EVENT_Q    = 3'h4;
	localparam logic [2:0]  PORT_PTR        = 3'h5;
	// Reset values.
	localparam logic [15:0] RST_IO_BASE     = 16'h0300;
	localparam logic [15:0] RST_IRQ_SEL     = 16'h0004;
	localparam logic [15:0] RST_DMA_SEL     = 16'h0003;
	localparam logic [15:0] RST_PTR         = 16'h3000;
	localparam logic [15:0] RST_CTL         = 16'h0000;
	// Self control fields.
	localparam int SELF_STANDBY   = 8;
	localparam int SELF_SUSPEND   = 9;
	localparam int SELF_FIRST_HOST_DRIVE_ENABLE      = 12;
	localparam int SELF_SECOND_HOST_DRIVE_ENABLE      = 13;
	localparam int SELF_HCB0      = 14;
	localparam int SELF_SECOND_HOST_DRIVE_VALUE      = 15;
	// Bus control fields.
	localparam int BUS_DMA_EN     = 7;
	localparam int BUS_MEM_EN     = 10;
	localparam int BUS_BURST      = 11;
	localparam int BUS_IRQ_EN     = 15;
	// Transmit command fields.
	localparam int TXC_THR_LO     = 6;
	localparam int TXC_NO_CRC     = 12;
	localparam int TXC_NO_PAD     = 13;
	// Event queue and bus status fields.
	localparam int EVQ_RX         = 2;
	localparam int EVQ_TX         = 3;
	localparam int STAT_TX_RDY    = 8;
	// Start thresholds in bytes and frame sizes.
	localparam logic [10:0] THR_5     = 11'h005;
	localparam logic [10:0] THR_381   = 11'h17d;
	localparam logic [10:0] THR_1021  = 11'h3fd;
	localparam logic [10:0] MIN_BODY  = 11'h03c;
	// FIFO shape.
	localparam int FIFO_W         = 16;
	localparam int FIFO_D         = 8;
endpackage : ihpff_pkg
`default_nettype wire

// [ihpff_port_asserts.sv]
// Pin-level checker of the host bus port.
`timescale 1ns/100ps
`default_nettype none
module ihpff_port_asserts #(
	parameter int NET_PULSE_CYC = 20,
	parameter int BURST_CYC     = 16
) (
	// Clock, reset and mode pins.
	input wire logic       i_clk_sys,
	input wire logic       i_rst_n,
	input wire logic       i_test_n,
	input wire logic       i_sleep_n,
	input wire logic       i_refresh_n,
	// Network events.
	input wire logic       i_rx_packet,
	input wire logic       i_tx_packet,
	input wire logic       i_collision,
	// Watched outputs.
	input wire logic       o_scan_mode,
	input wire logic       o_standby,
	input wire logic       o_suspend,
	input wire logic [2:0] o_indicator,
	input wire logic [3:0] o_irq_output_lines_oe,
	input wire logic [2:0] o_transfer_request_lines_oe,
	input wire logic [2:0] o_indicator_oe,
	input wire logic       o_io_wide_select_out,
	input wire logic       o_io_wide_select_out_oe
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// Standby changes the indicator's meaning, so standby, a low sleep input and scan mode are excluded.
	sequence s_net_event;
		(i_rx_packet || i_tx_packet || i_collision) && !o_standby && !o_scan_mode && i_sleep_n;
	endsequence
	sequence s_led_low;
		##[1:6] o_indicator_oe[2];
	endsequence
	AST_NET_PULSE: assert property (s_net_event |-> s_led_low)
		else $error("network indicator missed an event");
	AST_IRQ_ONE: assert property ($onehot0(o_irq_output_lines_oe))
		else $error("more than one interrupt line driven");
	AST_DMA_ONE: assert property ($onehot0(o_transfer_request_lines_oe))
		else $error("more than one request line driven");
	AST_WIDE_LOW: assert property (o_io_wide_select_out == 1'b0)
		else $error("wide select driven high");
	AST_IND_LOW: assert property (o_indicator == 3'h0)
		else $error("indicator driven high");
	AST_SCAN: assert property (!i_test_n [*8] |-> o_scan_mode)
		else $error("scan mode not entered");
	AST_NORMAL: assert property (i_test_n [*8] |-> !o_scan_mode)
		else $error("scan mode while test input high");
	AST_NO_SLEEP: assert property (i_sleep_n [*8] |-> !o_standby && !o_suspend)
		else $error("sleep mode without sleep input");
	AST_REFRESH: assert property (!i_refresh_n [*8] |-> !o_io_wide_select_out_oe)
		else $error("address hit during refresh");
endmodule : ihpff_port_asserts
bind ihpff_port ihpff_port_asserts #(.NET_PULSE_CYC(NET_PULSE_CYC), .BURST_CYC(BURST_CYC))
	i_chk (.*);
`default_nettype wire

// [ihpff_host.sv]
// Host processor model driving I/O cycles on the bus pins.
`timescale 1ns/100ps
`default_nettype none
module ihpff_host (
	// Clock and device read data.
	input  wire logic        i_clk_sys,
	input  wire logic [15:0] i_sd_dev,
	input  wire logic        i_sd_oe,
	// Bus pins.
	output logic      [15:0] o_sa,
	output logic      [15:0] o_sd,
	output var logic         o_aen,
	output var logic         o_ior_n,
	output var logic         o_iow_n,
	output var logic         o_refresh_n
);
	logic [15:0] wd;
	logic        drv;
	// A released bus shows the inverse of the last value, never a stale copy.
	assign o_sd = i_sd_oe ? i_sd_dev : (drv ? wd : ~wd);
	initial
	begin
		{drv, wd, o_sa, o_aen} = '0;
		{o_ior_n, o_iow_n, o_refresh_n} = 3'h7;
	end
	task automatic cyc(input logic [2:0] p, input logic wr, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge i_clk_sys);
		o_sa <= 16'h0300 + {12'h0, p, 1'b0};
		wd <= d;
		drv <= wr;
		@(posedge i_clk_sys);
		if (wr)
			o_iow_n <= 1'b0;
		else
			o_ior_n <= 1'b0;
		repeat (10) @(posedge i_clk_sys);
		q = o_sd;
		o_iow_n <= 1'b1;
		o_ior_n <= 1'b1;
		drv <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
	endtask : cyc
endmodule : ihpff_host
`default_nettype wire

// [test_isa_host_port_frame_flow.sv]
// Testbench of the host bus port with queue-based expectations.
`timescale 1ns/100ps
`default_nettype none
module test_isa_host_port_frame_flow;
	logic i_clk_sys = 0, i_rst_n = 0, i_test_n = 1, i_sleep_n = 1, i_tx_ready = 0;
	logic i_rx_valid = 0, i_rx_match = 0, i_rx_end = 0, i_rx_crc_ok = 0;
	logic i_link_ok, i_net_activity, i_rx_packet, i_tx_packet, i_collision;
	logic i_aen, i_ior_n, i_iow_n, i_refresh_n, o_sd_oe, o_io_wide_select_out;
	logic o_io_wide_select_out_oe, o_scan_mode, o_standby, o_suspend, o_tx_start;
	logic o_tx_crc_en, o_tx_valid, o_rx_ready;
	logic [15:0] i_sa, i_sd, o_sd, o_tx_data, i_rx_data = 0, v, d;
	logic [10:0] o_tx_pad_bytes, o_tx_len;
	logic [3:0] o_irq_output_lines, o_irq_output_lines_oe;
	logic [2:0] o_transfer_request_lines, o_transfer_request_lines_oe, o_indicator, o_indicator_oe;
	wire logic i_memr_n = 1, i_memw_n = 1, i_chipsel_n = 1, i_tx_done = 0;
	wire logic [2:0] i_transfer_ack_lines_n = 3'h7;
	int n_errors = 0, compares = 0, starts = 0, s0;
	logic [15:0] txq[$], rxq[$];
	ihpff_port #(.NET_PULSE_CYC(20), .BURST_CYC(16)) i_dut (.*);
	ihpff_host i_host (.i_clk_sys, .i_sd_dev(o_sd), .i_sd_oe(o_sd_oe), .o_sa(i_sa), .o_sd(i_sd),
		.o_aen(i_aen), .o_ior_n(i_ior_n), .o_iow_n(i_iow_n), .o_refresh_n(i_refresh_n));
	always #2 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys)
		{i_link_ok, i_net_activity, i_rx_packet, i_tx_packet, i_collision} <= 5'($urandom & $urandom);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [2:0] p, input logic [15:0] w);
		logic [15:0] q;
		i_host.cyc(p, 1'b1, w, q);
	endtask : wr
	task automatic rd(input logic [2:0] p, output logic [15:0] q);
		i_host.cyc(p, 1'b0, 16'h0, q);
	endtask : rd
	task automatic pw(input logic [15:0] a, input logic [15:0] w);
		wr(3'h5, a);
		wr(3'h6, w);
	endtask : pw
	task automatic pr(input logic [15:0] a, output logic [15:0] q);
		wr(3'h5, a);
		rd(3'h6, q);
	endtask : pr
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// Words drained after a start must arrive in the order written; drains before a start are not checked.
	always @(posedge i_clk_sys)
	begin
		if (o_tx_start)
			starts++;
		if (o_tx_valid && i_tx_ready && starts > s0)
			chk("tx_word", txq.pop_front(), o_tx_data);
	end
	initial
	begin
		#200000;
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(32'he4c5));
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rd(3'h5, v);
		chk("pointer", 16'h3000, v);
		pr(16'h0020, v);
		chk("io_base", 16'h0300, v);
		pr(16'h0022, v);
		chk("irq_sel", 16'h0004, v);
		pr(16'h0024, v);
		chk("dma_sel", 16'h0003, v);
		for (int n = 0; n < 4; n++)
		begin
			pw(16'h0022, 16'(n));
			chk("irq_oe", 16'(1 << n), {12'h0, o_irq_output_lines_oe});
			pw(16'h0024, 16'(n % 3));
			chk("dma_oe", 16'(1 << (n % 3)), {13'h0, o_transfer_request_lines_oe});
		end
		i_host.o_refresh_n <= 1'b0;
		pw(16'h0022, 16'h0000);
		i_host.o_refresh_n <= 1'b1;
		chk("irq_oe", 16'h0008, {12'h0, o_irq_output_lines_oe});
		$display("test select done");
		pw(16'h0116, 16'h8080);
		pw(16'h0024, 16'h0001);
		i_rx_valid <= 1'b1;
		i_rx_data <= 16'hdead;
		@(posedge i_clk_sys);
		i_rx_match <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			rxq.push_back(16'($urandom));
			i_rx_data <= rxq[k];
			@(posedge i_clk_sys);
			while (o_rx_ready !== 1'b1) @(posedge i_clk_sys);
		end
		{i_rx_valid, i_rx_end, i_rx_crc_ok} <= 3'h3;
		@(posedge i_clk_sys);
		i_rx_end <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		chk("dma_req", 16'h0002, {13'h0, o_transfer_request_lines});
		chk("irq", 16'h0008, {12'h0, o_irq_output_lines});
		rd(3'h4, v);
		chk("event_q", 16'h0004, v);
		rd(3'h4, v);
		chk("event_q", 16'h0000, v);
		chk("irq", 16'h0000, {12'h0, o_irq_output_lines});
		foreach (rxq[k])
		begin
			rd(3'h0, v);
			chk("rx_word", rxq[k], v);
		end
		chk("dma_req", 16'h0000, {13'h0, o_transfer_request_lines});
		$display("test receive done");
		i_tx_ready <= 1'b1;
		for (int c = 0; c < 5; c++)
		begin
			s0 = starts;
			i_tx_ready <= (c < 4);
			wr(3'h2, 16'((c % 4) << 6) | (c[0] ? 16'h3000 : 16'h0000));
			wr(3'h3, (c < 4) ? 16'd10 : 16'd20);
			for (int w = 0; w < ((c < 4) ? 5 : 10); w++)
			begin
				d = 16'($urandom);
				if (w < 9)
					txq.push_back(d);
				wr(3'h0, d);
				if (w == 3)
					chk("start_early", 16'(s0 + (c % 4 == 0)), 16'(starts));
			end
			chk("start", 16'(s0 + 1), 16'(starts));
			chk("crc", 16'(!c[0]), {15'h0, o_tx_crc_en});
			chk("len", (c < 4) ? 16'd10 : 16'd20, {5'h0, o_tx_len});
			chk("pad", c[0] ? 16'h0 : 16'((c < 4) ? 50 : 40), {5'h0, o_tx_pad_bytes});
		end
		i_tx_ready <= 1'b1;
		repeat (20) @(posedge i_clk_sys);
		chk("tx_left", 16'h0, 16'(txq.size()));
		$display("test transmit done");
		i_sleep_n <= 1'b0;
		pw(16'h0114, 16'h5100);
		chk("standby", 16'h1, {15'h0, o_standby});
		chk("link_led", 16'h1, {15'h0, o_indicator_oe[0]});
		i_sleep_n <= 1'b1;
		pw(16'h0114, 16'h1000);
		chk("standby", 16'h0, {15'h0, o_standby});
		chk("link_led", 16'h0, {15'h0, o_indicator_oe[0]});
		i_test_n <= 1'b0;
		repeat (12) @(posedge i_clk_sys);
		chk("scan", 16'h1, {15'h0, o_scan_mode});
		$display("test modes done");
		tally_and_finish();
	end
endmodule : test_isa_host_port_frame_flow
`default_nettype wire
